// *** rtl/asmd_regs.svh ***
`ifndef ASMD_REGS_SVH
`define ASMD_REGS_SVH

// opcode patterns, compared against the top bits of the first byte
`define ASMD_OPC_SBB_RM 6'b000110
`define ASMD_OPC_SBB_ACC 7'b0001110
`define ASMD_OPC_GRP1 6'b100000
`define ASMD_OPC_GRPFF 7'b1111111
`define ASMD_OPC_DEC_REG 5'b01001
`define ASMD_OPC_GRPF6 7'b1111011
`define ASMD_OPC_CMP_RM 6'b001110
`define ASMD_OPC_CMP_ACC 7'b0011110
`define ASMD_OPC_AAS 8'h3f
`define ASMD_OPC_DAS 8'h2f
`define ASMD_OPC_AAM 8'hd4

// reg-field selectors inside the grouped opcodes
`define ASMD_REG_SBB 3'h3
`define ASMD_REG_CMP 3'h7
`define ASMD_REG_DEC 3'h1
`define ASMD_REG_NEG 3'h3
`define ASMD_REG_MUL 3'h4
`define ASMD_REG_SIGNED_PRODUCT_OP 3'h5
`define ASMD_REG_DIV 3'h6

// mod/reg/rm field positions
`define ASMD_MOD_HI 7
`define ASMD_MOD_LO 6
`define ASMD_REG_HI 5
`define ASMD_REG_LO 3
`define ASMD_RM_HI 2
`define ASMD_RM_LO 0

// base clock counts
`define ASMD_CLK_RR 8'd3
`define ASMD_CLK_MEM_TO_REG 8'd9
`define ASMD_CLK_REG_TO_MEM 8'd16
`define ASMD_CLK_IMM_REG 8'd4
`define ASMD_CLK_IMM_MEM 8'd17
`define ASMD_CLK_ACC 8'd4
`define ASMD_CLK_DEC_REG 8'd2
`define ASMD_CLK_DEC_MEM 8'd15
`define ASMD_CLK_NEG_REG 8'd3
`define ASMD_CLK_NEG_MEM 8'd16
`define ASMD_CLK_CMP_MEM 8'd9
`define ASMD_CLK_ADJ 8'd4
`define ASMD_CLK_MUL8 8'd71
`define ASMD_CLK_MUL16 8'd124
`define ASMD_CLK_IMUL8 8'd90
`define ASMD_CLK_IMUL16 8'd144
`define ASMD_CLK_AAM 8'd83
`define ASMD_CLK_DIV8 8'd90
`define ASMD_CLK_DIV16 8'd155

// operand address cycle defaults
`define ASMD_EA_DIRECT 5'd6
`define ASMD_EA_BASE 5'd5
`define ASMD_EA_PAIR_FAST 5'd7
`define ASMD_EA_PAIR_SLOW 5'd8
`define ASMD_EA_DISP_ADD 5'd4

// status flag positions in the 6-bit flag vector
`define ASMD_F_OF 5
`define ASMD_F_SF 4
`define ASMD_F_ZF 3
`define ASMD_F_AF 2
`define ASMD_F_PF 1
`define ASMD_F_CF 0
`define ASMD_FLAGS_RST 6'h00

`endif

// *** rtl/asmd_pkg.sv ***
package asmd_pkg;
	typedef enum logic [4:0] {
		OP_NONE, OP_SBB_RM, OP_SBB_IMM, OP_SBB_ACC, OP_DEC_RM, OP_DEC_REG,
		OP_NEG, OP_CMP_RM, OP_CMP_IMM, OP_CMP_ACC, OP_AAS, OP_DAS,
		OP_MUL, OP_SIGNED_PRODUCT_OP, OP_AAM, OP_DIV, OP_GRP1, OP_GRPFF, OP_GRPF6
	} asmd_op_e;
	typedef enum logic [1:0] {DST_RM, DST_REG, DST_ACC} asmd_dst_e;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_MODRM = 3'b001, S_DISP = 3'b011,
		S_IMM = 3'b010, S_EXEC = 3'b110
	} asmd_state_e;
	typedef logic [5:0] asmd_flags_t;
endpackage

// *** rtl/asmd_ea_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface asmd_ea_if;
	logic [1:0] mode;
	logic [2:0] rm;
	logic is_mem;
	logic [1:0] disp_len;
	logic [4:0] ea_cycles;
	modport calc (input mode, rm, output is_mem, disp_len, ea_cycles);
	modport user (output mode, rm, input is_mem, disp_len, ea_cycles);
endinterface
`default_nettype wire

// *** rtl/asmd_ea.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asmd_regs.svh"
module asmd_ea #(
	parameter logic [4:0] EA_DIRECT = `ASMD_EA_DIRECT,
	parameter logic [4:0] EA_BASE = `ASMD_EA_BASE,
	parameter logic [4:0] EA_PAIR_FAST = `ASMD_EA_PAIR_FAST,
	parameter logic [4:0] EA_PAIR_SLOW = `ASMD_EA_PAIR_SLOW,
	parameter logic [4:0] EA_DISP_ADD = `ASMD_EA_DISP_ADD
) (
	// address mode fields in, cycle count out
	asmd_ea_if.calc ea
);
	logic direct;
	logic [4:0] base;

	// mode 3 names a register, so no address time at all
	assign direct = (ea.mode == 2'h0) && (ea.rm == 3'h6);
	assign ea.is_mem = (ea.mode != 2'h3);
	assign ea.disp_len = direct ? 2'h2 : (ea.mode == 2'h1) ? 2'h1 :
		(ea.mode == 2'h2) ? 2'h2 : 2'h0;

	// two-register sums are slower; the pairs 0 and 3 share one adder path
	always_comb begin
		unique case (ea.rm)
			3'h0, 3'h3: base = EA_PAIR_FAST;
			3'h1, 3'h2: base = EA_PAIR_SLOW;
			default: base = EA_BASE;
		endcase
	end

	assign ea.ea_cycles = !ea.is_mem ? 5'h00 : direct ? EA_DIRECT :
		(ea.mode == 2'h0) ? base : 5'(base + EA_DISP_ADD);
endmodule // asmd_ea
`default_nettype wire

// *** rtl/asmd_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asmd_regs.svh"
module asmd_decode (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// instruction byte stream
	input wire logic ibyte_valid,
	input wire logic [7:0] ibyte,
	output logic ibyte_ready,
	// operands and incoming flags, valid from the first execute cycle
	input wire logic [15:0] op_dst,
	input wire logic [15:0] op_src,
	input wire logic [15:0] op_ext,
	input wire asmd_pkg::asmd_flags_t flags_in,
	// decoded instruction
	output asmd_pkg::asmd_op_e op_q,
	output asmd_pkg::asmd_dst_e dst_sel_q,
	output logic word_q,
	output logic [2:0] reg_sel_q,
	output logic [1:0] mode_q,
	output logic [2:0] rm_sel_q,
	output logic is_mem,
	output logic [15:0] disp_q,
	output logic [15:0] imm_q,
	// execution results
	output logic busy,
	output logic done_q,
	output logic bad_op_q,
	output logic [15:0] result_q,
	output logic [15:0] result_hi_q,
	output logic wr_dst_q,
	output logic wr_hi_q,
	output logic div_error_q,
	output asmd_pkg::asmd_flags_t flags_q
);
	import asmd_pkg::*;

	asmd_state_e state_q;
	logic [1:0] left_q;
	logic [7:0] cnt_q;
	logic first_q;
	logic sext_q;
	logic dir_q;
	logic [7:0] total;
	logic take;
	asmd_ea_if eab ();

	asmd_ea u_ea (
		.ea(eab.calc)
	);

	assign eab.mode = mode_q;
	assign eab.rm = rm_sel_q;
	assign is_mem = (op_q == OP_DEC_REG || op_q == OP_AAS || op_q == OP_DAS ||
		op_q == OP_AAM || op_q == OP_SBB_ACC || op_q == OP_CMP_ACC) ? 1'b0 : eab.is_mem;
	assign ibyte_ready = (state_q != S_EXEC);
	assign take = ibyte_valid && ibyte_ready;
	assign busy = (state_q != S_IDLE);

	// base clocks per form, plus address time for memory operands
	function automatic logic [7:0] clocks_for(asmd_op_e op, logic w, logic d, logic mem,
		logic [4:0] ea);
		logic [7:0] b;
		b = 8'h00;
		unique case (op)
			OP_SBB_RM: b = !mem ? `ASMD_CLK_RR : d ? `ASMD_CLK_MEM_TO_REG :
				`ASMD_CLK_REG_TO_MEM;
			OP_SBB_IMM, OP_CMP_IMM: b = mem ? `ASMD_CLK_IMM_MEM : `ASMD_CLK_IMM_REG;
			OP_SBB_ACC, OP_CMP_ACC: b = `ASMD_CLK_ACC;
			OP_DEC_RM: b = mem ? `ASMD_CLK_DEC_MEM : `ASMD_CLK_DEC_REG;
			OP_DEC_REG: b = `ASMD_CLK_DEC_REG;
			OP_NEG: b = mem ? `ASMD_CLK_NEG_MEM : `ASMD_CLK_NEG_REG;
			OP_CMP_RM: b = mem ? `ASMD_CLK_CMP_MEM : `ASMD_CLK_RR;
			OP_AAS, OP_DAS: b = `ASMD_CLK_ADJ;
			OP_MUL: b = w ? `ASMD_CLK_MUL16 : `ASMD_CLK_MUL8;
			OP_SIGNED_PRODUCT_OP: b = w ? `ASMD_CLK_IMUL16 : `ASMD_CLK_IMUL8;
			OP_AAM: b = `ASMD_CLK_AAM;
			OP_DIV: b = w ? `ASMD_CLK_DIV16 : `ASMD_CLK_DIV8;
			default: b = 8'h01;
		endcase
		clocks_for = mem ? 8'(b + {3'h0, ea}) : b;
	endfunction

	// subtract a - b - cin at byte or word width; returns {flags, difference}
	function automatic logic [21:0] sub_flags(logic [15:0] a, logic [15:0] b, logic cin,
		logic w);
		logic [8:0] d8;
		logic [16:0] d16;
		logic [15:0] r;
		logic sa;
		logic sb;
		logic sr;
		asmd_flags_t f;
		d8 = {1'b0, a[7:0]} - {1'b0, b[7:0]} - {8'h00, cin};
		d16 = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
		r = w ? d16[15:0] : {8'h00, d8[7:0]};
		sa = w ? a[15] : a[7];
		sb = w ? b[15] : b[7];
		sr = w ? r[15] : r[7];
		f[`ASMD_F_CF] = w ? d16[16] : d8[8];
		f[`ASMD_F_OF] = (sa ^ sb) & (sa ^ sr);
		f[`ASMD_F_AF] = a[4] ^ b[4] ^ r[4];
		f[`ASMD_F_ZF] = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
		f[`ASMD_F_SF] = sr;
		f[`ASMD_F_PF] = ~^r[7:0];
		sub_flags = {f, r};
	endfunction

	assign total = clocks_for(op_q, word_q, dir_q, is_mem, eab.ea_cycles);

	// opcode classification and field capture
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			op_q <= OP_NONE;
			dst_sel_q <= DST_RM;
			word_q <= 1'b0;
			dir_q <= 1'b0;
			sext_q <= 1'b0;
			reg_sel_q <= 3'h0;
			mode_q <= 2'h3;
			rm_sel_q <= 3'h0;
		end else if (take && state_q == S_IDLE) begin
			word_q <= ibyte[0];
			dir_q <= ibyte[1];
			sext_q <= ibyte[1];
			mode_q <= 2'h3;
			dst_sel_q <= ibyte[1] ? DST_REG : DST_RM;
			if (ibyte[7:2] == `ASMD_OPC_SBB_RM) op_q <= OP_SBB_RM;
			else if (ibyte[7:2] == `ASMD_OPC_CMP_RM) op_q <= OP_CMP_RM;
			else if (ibyte[7:2] == `ASMD_OPC_GRP1) begin
				op_q <= OP_GRP1;
				dst_sel_q <= DST_RM;
			end else if (ibyte[7:1] == `ASMD_OPC_SBB_ACC || ibyte[7:1] == `ASMD_OPC_CMP_ACC) begin
				op_q <= ibyte[5] ? OP_CMP_ACC : OP_SBB_ACC;
				dst_sel_q <= DST_ACC;
			end else if (ibyte[7:1] == `ASMD_OPC_GRPFF) begin
				op_q <= OP_GRPFF;
				dst_sel_q <= DST_RM;
			end else if (ibyte[7:1] == `ASMD_OPC_GRPF6) begin
				op_q <= OP_GRPF6;
				dst_sel_q <= DST_RM;
			end else if (ibyte[7:3] == `ASMD_OPC_DEC_REG) begin
				op_q <= OP_DEC_REG;
				word_q <= 1'b1;
				reg_sel_q <= ibyte[2:0];
				dst_sel_q <= DST_REG;
			end else if (ibyte == `ASMD_OPC_AAS || ibyte == `ASMD_OPC_DAS ||
				ibyte == `ASMD_OPC_AAM) begin
				op_q <= (ibyte == `ASMD_OPC_AAS) ? OP_AAS : (ibyte == `ASMD_OPC_DAS) ?
					OP_DAS : OP_AAM;
				word_q <= 1'b0;
				dst_sel_q <= DST_ACC;
			end else op_q <= OP_NONE;
		end else if (take && state_q == S_MODRM) begin
			mode_q <= ibyte[`ASMD_MOD_HI:`ASMD_MOD_LO];
			reg_sel_q <= ibyte[`ASMD_REG_HI:`ASMD_REG_LO];
			rm_sel_q <= ibyte[`ASMD_RM_HI:`ASMD_RM_LO];
			// group opcodes resolve on the reg field
			unique case (op_q)
				OP_GRP1: op_q <= (ibyte[5:3] == `ASMD_REG_SBB) ? OP_SBB_IMM :
					(ibyte[5:3] == `ASMD_REG_CMP) ? OP_CMP_IMM : OP_NONE;
				OP_GRPFF: op_q <= (ibyte[5:3] == `ASMD_REG_DEC) ? OP_DEC_RM : OP_NONE;
				OP_GRPF6: begin
					unique case (ibyte[5:3])
						`ASMD_REG_NEG: op_q <= OP_NEG;
						`ASMD_REG_MUL: op_q <= OP_MUL;
						`ASMD_REG_SIGNED_PRODUCT_OP: op_q <= OP_SIGNED_PRODUCT_OP;
						`ASMD_REG_DIV: op_q <= OP_DIV;
						default: op_q <= OP_NONE;
					endcase
				end
				default: op_q <= op_q;
			endcase
		end
	end

	// byte fetch sequencing and execute countdown
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			left_q <= 2'h0;
			cnt_q <= 8'h00;
			first_q <= 1'b0;
			disp_q <= 16'h0000;
			imm_q <= 16'h0000;
		end else begin
			first_q <= 1'b0;
			unique case (state_q)
				S_IDLE: if (take) begin
					imm_q <= 16'h0000;
					disp_q <= 16'h0000;
					if (ibyte[7:2] == `ASMD_OPC_SBB_RM || ibyte[7:2] == `ASMD_OPC_CMP_RM ||
						ibyte[7:2] == `ASMD_OPC_GRP1 || ibyte[7:1] == `ASMD_OPC_GRPFF ||
						ibyte[7:1] == `ASMD_OPC_GRPF6)
						state_q <= S_MODRM;
					else if (ibyte[7:1] == `ASMD_OPC_SBB_ACC ||
						ibyte[7:1] == `ASMD_OPC_CMP_ACC) begin
						state_q <= S_IMM;
						left_q <= ibyte[0] ? 2'h2 : 2'h1;
					end else if (ibyte == `ASMD_OPC_AAM) begin
						state_q <= S_IMM;
						left_q <= 2'h1;
					end else if (ibyte[7:3] == `ASMD_OPC_DEC_REG || ibyte == `ASMD_OPC_AAS ||
						ibyte == `ASMD_OPC_DAS) begin
						state_q <= S_EXEC;
						first_q <= 1'b1;
					end
				end
				S_MODRM: if (take) begin
					// address time needs the new mode, so count loads on the next state
					if (ibyte[7:6] != 2'h3 && (ibyte[7:6] != 2'h0 || ibyte[2:0] == 3'h6)) begin
						state_q <= S_DISP;
						left_q <= (ibyte[7:6] == 2'h1) ? 2'h1 : 2'h2;
					end else if (op_q == OP_GRP1) begin
						state_q <= S_IMM;
						left_q <= ({sext_q, word_q} == 2'b01) ? 2'h2 : 2'h1;
					end else begin
						state_q <= S_EXEC;
						first_q <= 1'b1;
					end
				end
				S_DISP: if (take) begin
					if (eab.disp_len == 2'h2) disp_q <= {ibyte, disp_q[15:8]};
					else disp_q <= {{8{ibyte[7]}}, ibyte};
					left_q <= 2'(left_q - 2'h1);
					if (left_q == 2'h1) begin
						if (op_q == OP_SBB_IMM || op_q == OP_CMP_IMM) begin
							state_q <= S_IMM;
							left_q <= ({sext_q, word_q} == 2'b01) ? 2'h2 : 2'h1;
						end else begin
							state_q <= S_EXEC;
							first_q <= 1'b1;
						end
					end
				end
				S_IMM: if (take) begin
					// low byte first; a lone byte sign-extends when s and w are set
					if (left_q == 2'h2) imm_q <= {8'h00, ibyte};
					else if (imm_q[15:8] == 8'h00 && word_q && {sext_q, word_q} == 2'b01 &&
						dst_sel_q != DST_ACC || (dst_sel_q == DST_ACC && word_q &&
						op_q != OP_AAM))
						imm_q <= {ibyte, imm_q[7:0]};
					else imm_q <= (sext_q && word_q && op_q != OP_AAM) ?
						{{8{ibyte[7]}}, ibyte} : {8'h00, ibyte};
					left_q <= 2'(left_q - 2'h1);
					if (left_q == 2'h1) begin
						state_q <= S_EXEC;
						first_q <= 1'b1;
					end
				end
				S_EXEC: begin
					if (first_q) cnt_q <= 8'(total - 8'h01);
					else cnt_q <= 8'(cnt_q - 8'h01);
					if (op_q == OP_NONE || op_q == OP_GRP1 || op_q == OP_GRPFF ||
						op_q == OP_GRPF6 || (!first_q && cnt_q == 8'h01) ||
						(first_q && total == 8'h01))
						state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// arithmetic on the first execute cycle, registered at its end, ahead of done_q
	always_ff @(posedge mclk or negedge rst_n) begin
		logic [21:0] s;
		logic [15:0] b;
		logic [31:0] p;
		logic [7:0] al;
		logic [7:0] ah;
		if (!rst_n) begin
			result_q <= 16'h0000;
			result_hi_q <= 16'h0000;
			wr_dst_q <= 1'b0;
			wr_hi_q <= 1'b0;
			div_error_q <= 1'b0;
			flags_q <= `ASMD_FLAGS_RST;
		end else if (first_q) begin
			b = (op_q == OP_SBB_IMM || op_q == OP_CMP_IMM || dst_sel_q == DST_ACC) ?
				imm_q : op_src;
			s = 22'h000000;
			p = 32'h00000000;
			al = op_dst[7:0];
			ah = op_dst[15:8];
			flags_q <= flags_in;
			wr_dst_q <= 1'b1;
			wr_hi_q <= 1'b0;
			div_error_q <= 1'b0;
			result_hi_q <= 16'h0000;
			unique case (op_q)
				OP_SBB_RM, OP_SBB_IMM, OP_SBB_ACC, OP_CMP_RM, OP_CMP_IMM, OP_CMP_ACC: begin
					s = sub_flags(op_dst, b, (op_q == OP_SBB_RM || op_q == OP_SBB_IMM ||
						op_q == OP_SBB_ACC) && flags_in[`ASMD_F_CF], word_q);
					flags_q <= s[21:16];
					result_q <= s[15:0];
					wr_dst_q <= !(op_q == OP_CMP_RM || op_q == OP_CMP_IMM ||
						op_q == OP_CMP_ACC);
				end
				OP_DEC_RM, OP_DEC_REG: begin
					s = sub_flags(op_dst, 16'h0001, 1'b0, word_q);
					flags_q <= {s[21:17], flags_in[`ASMD_F_CF]};
					result_q <= s[15:0];
				end
				OP_NEG: begin
					s = sub_flags(16'h0000, op_dst, 1'b0, word_q);
					flags_q <= {s[21:17], s[15:0] != 16'h0000};
					result_q <= s[15:0];
				end
				OP_AAS: begin
					if (al[3:0] > 4'h9 || flags_in[`ASMD_F_AF]) begin
						al = 8'(al - 8'h06);
						ah = 8'(ah - 8'h01);
						flags_q[`ASMD_F_AF] <= 1'b1;
						flags_q[`ASMD_F_CF] <= 1'b1;
					end else begin
						flags_q[`ASMD_F_AF] <= 1'b0;
						flags_q[`ASMD_F_CF] <= 1'b0;
					end
					result_q <= {ah, 4'h0, al[3:0]};
				end
				OP_DAS: begin
					s = sub_flags({8'h00, al}, 16'h0006, 1'b0, 1'b0);
					if (al[3:0] > 4'h9 || flags_in[`ASMD_F_AF]) al = s[7:0];
					if (op_dst[7:0] > 8'h99 || flags_in[`ASMD_F_CF]) al = 8'(al - 8'h60);
					flags_q <= {flags_in[`ASMD_F_OF], al[7], al == 8'h00,
						op_dst[3:0] > 4'h9 || flags_in[`ASMD_F_AF], ~^al,
						op_dst[7:0] > 8'h99 || flags_in[`ASMD_F_CF]};
					result_q <= {ah, al};
				end
				OP_AAM: begin
					// a zero base cannot divide; flagged and the accumulator kept
					if (imm_q[7:0] == 8'h00) begin
						div_error_q <= 1'b1;
						wr_dst_q <= 1'b0;
					end else begin
						ah = al / imm_q[7:0];
						al = al % imm_q[7:0];
						flags_q[`ASMD_F_SF] <= al[7];
						flags_q[`ASMD_F_ZF] <= (al == 8'h00);
						flags_q[`ASMD_F_PF] <= ~^al;
					end
					result_q <= {ah, al};
				end
				OP_MUL, OP_SIGNED_PRODUCT_OP: begin
					if (op_q == OP_MUL)
						p = word_q ? 32'(op_dst * op_src) : {16'h0000, 16'(al * op_src[7:0])};
					else if (word_q) p = 32'($signed(op_dst) * $signed(op_src));
					else p = {16'h0000, 16'($signed(al) * $signed(op_src[7:0]))};
					result_q <= p[15:0];
					result_hi_q <= p[31:16];
					wr_hi_q <= word_q;
					// upper half beyond the low half's reach sets both flags
					flags_q[`ASMD_F_OF] <= (op_q == OP_MUL) ? (word_q ? p[31:16] != 16'h0000 :
						p[15:8] != 8'h00) : (word_q ? p[31:16] != {16{p[15]}} :
						p[15:8] != {8{p[7]}});
					flags_q[`ASMD_F_CF] <= (op_q == OP_MUL) ? (word_q ? p[31:16] != 16'h0000 :
						p[15:8] != 8'h00) : (word_q ? p[31:16] != {16{p[15]}} :
						p[15:8] != {8{p[7]}});
				end
				OP_DIV: begin
					// quotient must fit the low half, else nothing is written
					if (word_q ? (op_src == 16'h0000 || op_ext >= op_src) :
						(op_src[7:0] == 8'h00 || ah >= op_src[7:0])) begin
						div_error_q <= 1'b1;
						wr_dst_q <= 1'b0;
					end else if (word_q) begin
						result_q <= 16'({op_ext, op_dst} / {16'h0000, op_src});
						result_hi_q <= 16'({op_ext, op_dst} % {16'h0000, op_src});
						wr_hi_q <= 1'b1;
					end else begin
						result_q <= {8'(op_dst % {8'h00, op_src[7:0]}),
							8'(op_dst / {8'h00, op_src[7:0]})};
					end
				end
				default: wr_dst_q <= 1'b0;
			endcase
		end
	end

	// completion and rejection pulses
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			bad_op_q <= 1'b0;
		end else begin
			done_q <= (state_q == S_EXEC) && op_q != OP_NONE && op_q != OP_GRP1 &&
				op_q != OP_GRPFF && op_q != OP_GRPF6 &&
				((!first_q && cnt_q == 8'h01) || (first_q && total == 8'h01));
			bad_op_q <= (state_q == S_EXEC) && first_q && (op_q == OP_NONE ||
				op_q == OP_GRP1 || op_q == OP_GRPFF || op_q == OP_GRPF6);
		end
	end
endmodule // asmd_decode
`default_nettype wire

// *** verif/asmd_decode_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asmd_regs.svh"
module asmd_chk
	import asmd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// byte stream
	input wire logic ibyte_valid,
	input wire logic [7:0] ibyte,
	input wire logic ibyte_ready,
	// execution results
	input wire logic busy,
	input wire logic done_q,
	input wire asmd_pkg::asmd_op_e op_q,
	input wire logic word_q,
	input wire logic [15:0] result_q,
	input wire logic wr_dst_q,
	input wire asmd_pkg::asmd_flags_t flags_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// opcode byte taken while idle; busy keeps later bytes out
	logic first_tk;
	assign first_tk = ibyte_valid && ibyte_ready && !busy;

	// four execute cycles with the byte bus shut, then the finish pulse
	sequence exec_four;
		!ibyte_ready [*4];
	endsequence
	sequence finish_now;
		done_q && ibyte_ready;
	endsequence

	dec_reg_time_a: assert property (first_tk && ibyte[7:3] == `ASMD_OPC_DEC_REG
		|=> !done_q [*2] ##1 done_q) else $error("short decrement took wrong time");
	adjust_time_a: assert property (first_tk && (ibyte == `ASMD_OPC_AAS ||
		ibyte == `ASMD_OPC_DAS) |=> exec_four ##1 finish_now) else $error("adjust timing");
	done_pulse_a: assert property (done_q |=> !done_q) else $error("done longer than one cycle");
	ready_busy_a: assert property (!ibyte_ready |-> busy) else $error("ready low while idle");
	cmp_nowrite_a: assert property (done_q && op_q inside {OP_CMP_RM, OP_CMP_IMM,
		OP_CMP_ACC} |-> !wr_dst_q) else $error("compare wrote back");
	neg_carry_a: assert property (done_q && op_q == OP_NEG |-> flags_q[`ASMD_F_CF] ==
		(word_q ? result_q != 16'h0 : result_q[7:0] != 8'h0)) else $error("negate carry");
	mul_flags_a: assert property (done_q && op_q inside {OP_MUL, OP_SIGNED_PRODUCT_OP}
		|-> flags_q[`ASMD_F_OF] == flags_q[`ASMD_F_CF]) else $error("product flags");
	acc_width_a: assert property (first_tk && ibyte[7:1] == `ASMD_OPC_SBB_ACC
		|=> word_q == $past(ibyte[0])) else $error("accumulator width");
endmodule // asmd_chk

bind asmd_decode asmd_chk u_asmd_chk (.mclk(mclk), .rst_n(rst_n), .ibyte_valid(ibyte_valid),
	.ibyte(ibyte), .ibyte_ready(ibyte_ready), .busy(busy), .done_q(done_q), .op_q(op_q),
	.word_q(word_q), .result_q(result_q), .wr_dst_q(wr_dst_q), .flags_q(flags_q));
`default_nettype wire

// *** verif/asmd_fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asmd_fetch_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// byte stream
	input wire logic ibyte_ready,
	output logic ibyte_valid,
	output logic [7:0] ibyte
);
	logic [7:0] fifo[$];
	logic took;
	logic slow;
	logic gap;

	// handshake seen with pre-edge values, so no race with the decoder
	always @(posedge mclk) took <= ibyte_valid && ibyte_ready;

	// drive after the edge; an offered byte stays until taken
	initial begin
		ibyte_valid = 1'b0;
		ibyte = 8'h00;
		slow = 1'b0;
		gap = 1'b0;
		forever begin
			@(posedge mclk);
			#1;
			if (took && fifo.size() > 0) void'(fifo.pop_front());
			gap = slow && !gap;
			if (!rst_n || !(ibyte_valid && !took)) begin
				ibyte_valid = rst_n && fifo.size() > 0 && !gap;
				// an idle bus flips every bit of its byte each cycle
				ibyte = ibyte_valid ? fifo[0] : ~ibyte;
			end
		end
	end
endmodule // asmd_fetch_model
`default_nettype wire

// *** verif/test_arith_sub_mul_div_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asmd_regs.svh"
module test_arith_sub_mul_div_decode;
	import asmd_pkg::*;
	logic mclk, rst_n, ibyte_valid, ibyte_ready, busy, done_q, word_q, wr_dst_q, is_mem;
	logic [7:0] ibyte;
	logic [15:0] op_dst, op_src, op_ext, result_q, imm_q;
	asmd_flags_t flags_in, flags_q;
	asmd_op_e op_q;
	asmd_dst_e dst_sel_q;
	logic bad_op_q, div_error_q;
	logic [15:0] disp_q, result_hi_q;
	logic [7:0] opc;
	int num_errors = 0, checked = 0, seed = 88, cyc = 0, acc_cyc = 0, k, r;
	logic fix_ops = 1'b0;

	asmd_decode u_asmd_decode (.mclk(mclk), .rst_n(rst_n), .ibyte_valid(ibyte_valid),
		.ibyte(ibyte), .ibyte_ready(ibyte_ready), .op_dst(op_dst), .op_src(op_src),
		.op_ext(op_ext), .flags_in(flags_in), .op_q(op_q), .dst_sel_q(dst_sel_q),
		.word_q(word_q), .reg_sel_q(), .mode_q(), .rm_sel_q(), .is_mem(is_mem),
		.disp_q(disp_q), .imm_q(imm_q), .busy(busy), .done_q(done_q), .bad_op_q(bad_op_q),
		.result_q(result_q), .result_hi_q(result_hi_q), .wr_dst_q(wr_dst_q), .wr_hi_q(),
		.div_error_q(div_error_q), .flags_q(flags_q));
	asmd_fetch_model u_asmd_fetch_model (.mclk(mclk), .rst_n(rst_n),
		.ibyte_ready(ibyte_ready), .ibyte_valid(ibyte_valid), .ibyte(ibyte));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// edge count and the edge of the latest byte accepted
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (ibyte_valid && ibyte_ready) acc_cyc <= cyc;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (exp !== got) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// fresh operands unless a scenario pinned them
	task automatic prep();
		op_dst = 16'($random(seed));
		op_src = 16'($random(seed));
		op_ext = 16'($random(seed));
		flags_in = 6'($random(seed));
	endtask

	// send one instruction, first byte in the top byte, and time it
	task automatic go(input logic [47:0] b, input int len, input int n);
		int w;
		if (!fix_ops) prep();
		for (w = len - 1; w >= 0; w--) u_asmd_fetch_model.fifo.push_back(b[8*w +: 8]);
		w = 0;
		do begin
			@(posedge mclk);
			#1;
			w++;
		end while (done_q !== 1'b1 && w < 400);
		if (w >= 400) begin
			num_errors++;
			$display("MISMATCH done_q expected 1 seen timeout");
			close_out();
		end
		check("clocks", n, cyc - 1 - acc_cyc);
		$display("test %h done", b);
	endtask

	// word result of the ops used with result checks
	function automatic logic [15:0] exp_res(input logic [7:0] o);
		case (o)
			8'h1b: return op_dst - op_src - 16'(flags_in[`ASMD_F_CF]);
			8'hf7: return -op_dst;
			8'hf6: return op_dst[7:0] * op_src[7:0];
			default: return op_dst - 16'h1;
		endcase
	endfunction

	initial begin
		rst_n = 1'b0;
		prep();
		repeat (12) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		go(8'h4b, 1, 2);
		check("dec", exp_res(8'h48), result_q);
		go(16'hfec9, 2, 2);
		go(32'hff0e1234, 4, 21);
		check("disp16", 16'h3412, disp_q);
		check("is_mem", 1, is_mem);
		// one displacement byte, sign-extended, base register plus offset
		go(24'hff4f85, 3, 24);
		check("disp8", 16'hff85, disp_q);
		go(16'h1bc1, 2, 3);
		check("sbb", exp_res(8'h1b), result_q);
		u_asmd_fetch_model.slow = 1'b1;
		go(32'h1b061234, 4, 15);
		go(32'h19061234, 4, 22);
		go(24'h83d980, 3, 4);
		check("imm_sx", 16'hff80, imm_q);
		go(32'h81d97856, 4, 4);
		check("imm_w", 16'h5678, imm_q);
		go(40'h801e123455, 5, 23);
		go(16'h1c7f, 2, 4);
		go(24'h1d3412, 3, 4);
		check("imm_acc", 16'h1234, imm_q);
		u_asmd_fetch_model.slow = 1'b0;
		go(32'hf71e1234, 4, 22);
		go(32'h39061234, 4, 15);
		check("dst_rm", DST_RM, dst_sel_q);
		go(24'h83f905, 3, 4);
		go(48'h813e12347856, 6, 23);
		go(16'h3c10, 2, 4);
		go(24'h3d3412, 3, 4);
		go(8'h3f, 1, 4);
		go(8'h2f, 1, 4);
		go(16'hf6e1, 2, 71);
		check("mul", exp_res(8'hf6), result_q);
		go(16'hf7e1, 2, 124);
		check("mul_hi", 32'(op_dst) * 32'(op_src) >> 16, result_hi_q);
		go(16'hf6e9, 2, 90);
		go(16'hf7e9, 2, 144);
		go(16'hd40a, 2, 83);
		// divisor and dividend kept small so no divide error
		fix_ops = 1'b1;
		op_dst = 16'h0010;
		op_src = 16'h0003;
		op_ext = 16'h0000;
		go(16'hf6f1, 2, 90);
		check("div8", 16'h0105, result_q);
		go(16'hf7f1, 2, 155);
		check("div16", 16'h0005, result_q);
		check("div16_hi", 16'h0001, result_hi_q);
		// zero divisor: error raised, nothing written, finish still pulses
		op_src = 16'h0000;
		go(16'hf6f1, 2, 90);
		check("div_err", 1, div_error_q);
		check("div_wr", 0, wr_dst_q);
		// corner: zero operand leaves carry clear
		op_dst = 16'h0000;
		go(16'hf7d9, 2, 3);
		check("neg_cf", 0, flags_q[`ASMD_F_CF]);
		fix_ops = 1'b0;
		go(16'h3bc1, 2, 3);
		check("cmp_wr", 0, wr_dst_q);
		check("cmp_cf", op_dst < op_src, flags_q[`ASMD_F_CF]);
		check("dst_reg", DST_REG, dst_sel_q);
		// unsupported reg field in the f6 group: reject pulse, no finish
		u_asmd_fetch_model.fifo.push_back(8'hf7);
		u_asmd_fetch_model.fifo.push_back(8'hd0);
		k = 0;
		while (bad_op_q !== 1'b1 && k < 40) begin
			@(posedge mclk);
			#1;
			k++;
		end
		check("bad_op", 1, bad_op_q);
		check("bad_done", 0, done_q);
		if (k >= 40) close_out();
		// random register forms, back to back
		for (k = 0; k < 24; k++) begin
			r = $random(seed) & 7;
			case ($unsigned($random(seed)) % 3)
				0: opc = 8'h1b;
				1: opc = 8'hf7;
				default: opc = 8'h48;
			endcase
			case (opc)
				8'h1b: go({opc, 8'hc0 | 8'(r)}, 2, 3);
				8'hf7: go({opc, 8'hd8 | 8'(r)}, 2, 3);
				default: go({opc | 8'(r)}, 1, 2);
			endcase
			check("rand_res", exp_res(opc), result_q);
		end
		close_out();
	end
endmodule // test_arith_sub_mul_div_decode
`default_nettype wire
